//--- idls_pkg.sv
`default_nettype none
package idls_pkg;

    // Register addresses in the device's byte-wide register space
    localparam logic [7:0] ADDR_DIV1_HIGH   = 8'h2b;
    localparam logic [7:0] ADDR_DIV1_MID    = 8'h2c;
    localparam logic [7:0] ADDR_DIV1_LOW    = 8'h2d;
    localparam logic [7:0] ADDR_DIV2_HIGH   = 8'h2e;
    localparam logic [7:0] ADDR_DIV2_MID    = 8'h2f;
    localparam logic [7:0] ADDR_DIV2_LOW    = 8'h30;
    localparam logic [7:0] ADDR_RATE_SELECT = 8'h37;
    localparam logic [7:0] ADDR_ACTIVE      = 8'h80;
    localparam logic [7:0] ADDR_LOSS_LIVE   = 8'h81;

    // Divider field layout: code is ratio minus one
    localparam int         DIV_W            = 19;
    localparam int         DIV_HIGH_W       = 3;
    localparam int         DIV_HIGH_LSB     = 16;
    localparam int         DIV_MID_LSB      = 8;
    localparam logic [2:0] DIV_HIGH_RST     = 3'h0;
    localparam logic [7:0] DIV_MID_RST      = 8'h00;
    localparam logic [7:0] DIV1_LOW_RST     = 8'h09;
    localparam logic [7:0] DIV2_LOW_RST     = 8'h00;

    // Rate select layout
    localparam int         RATE_W           = 3;
    localparam int         RATE2_LSB        = 3;
    localparam int         RATE1_LSB        = 0;
    localparam logic [2:0] RATE_MAX_LEGAL   = 3'h5;
    localparam logic [2:0] RATE_RST         = 3'h0;

    // Status bit positions
    localparam int         ACT1_BIT         = 0;
    localparam int         ACT2_BIT         = 1;
    localparam int         LOSS_REF_BIT     = 0;
    localparam int         LOSS_FIRST_BIT   = 1;
    localparam int         LOSS_SECOND_BIT  = 2;
    localparam logic [7:0] ACTIVE_RSVD_VAL  = 8'h20;
    localparam logic [7:0] READ_ZERO        = 8'h00;

    // Register port request from the serial interface engine
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } idls_bus_req_s;

    // Whole state of the bank
    typedef struct packed {
        logic [DIV_W-1:0]  div1;
        logic [DIV_W-1:0]  div2;
        logic [DIV_W:0]    ratio1;
        logic [DIV_W:0]    ratio2;
        logic [RATE_W-1:0] rate1;
        logic [RATE_W-1:0] rate2;
        logic              act1;
        logic              act2;
        logic [2:0]        loss;
        logic [7:0]        rdata;
        logic              rvalid;
    } idls_state_s;

endpackage
`default_nettype wire

//--- idls_regs.sv
`default_nettype none
module idls_regs
    import idls_pkg::*;
(
    // Clock and reset
    input  wire logic              ref_clk_i,
    input  wire logic              rst_b_i,
    // Register port
    input  wire idls_bus_req_s     bus_req_i,
    output logic [7:0]             rdata_o,
    output logic                   rvalid_o,
    // Live conditions from the clock path
    input  wire logic              first_input_selected_i,
    input  wire logic              second_input_selected_i,
    input  wire logic              first_input_loss_live_i,
    input  wire logic              second_input_loss_live_i,
    input  wire logic              reference_loss_live_i,
    // Configuration to the clock path
    output logic [DIV_W-1:0]       first_input_divider_o,
    output logic [DIV_W-1:0]       second_input_divider_o,
    output logic [DIV_W:0]         first_input_ratio_o,
    output logic [DIV_W:0]         second_input_ratio_o,
    output logic [RATE_W-1:0]      first_input_range_code_o,
    output logic [RATE_W-1:0]      second_input_range_code_o,
    // Status to the clock path and held-flag logic
    output logic                   first_input_active_o,
    output logic                   second_input_active_o,
    output logic [2:0]             loss_live_o
);

    idls_state_s state;
    idls_state_s next_state;

    // Ratio is one more than the stored code; widened so the top code fits
    function automatic logic [DIV_W:0] ratio_of(input logic [DIV_W-1:0] code);
        ratio_of = {1'b0, code} + {{DIV_W{1'b0}}, 1'b1};
    endfunction

    // Reserved range codes are never accepted
    function automatic logic [RATE_W-1:0] rate_upd(input logic [RATE_W-1:0] old_code,
                                                    input logic [RATE_W-1:0] new_code);
        rate_upd = (new_code <= RATE_MAX_LEGAL) ? new_code : old_code;
    endfunction

    // Next-state logic: writes, live status, read data
    always_comb
    begin
        next_state        = state;
        next_state.rvalid = 1'b0;
        if (bus_req_i.wr)
        begin
            unique case (bus_req_i.addr)
                ADDR_DIV1_HIGH:
                    next_state.div1[DIV_W-1:DIV_HIGH_LSB] = bus_req_i.wdata[DIV_HIGH_W-1:0];
                ADDR_DIV1_MID:
                    next_state.div1[DIV_HIGH_LSB-1:DIV_MID_LSB] = bus_req_i.wdata;
                ADDR_DIV1_LOW:
                    next_state.div1[DIV_MID_LSB-1:0] = bus_req_i.wdata;
                ADDR_DIV2_HIGH:
                    next_state.div2[DIV_W-1:DIV_HIGH_LSB] = bus_req_i.wdata[DIV_HIGH_W-1:0];
                ADDR_DIV2_MID:
                    next_state.div2[DIV_HIGH_LSB-1:DIV_MID_LSB] = bus_req_i.wdata;
                ADDR_DIV2_LOW:
                    next_state.div2[DIV_MID_LSB-1:0] = bus_req_i.wdata;
                ADDR_RATE_SELECT:
                begin
                    next_state.rate1 = rate_upd(state.rate1,
                        bus_req_i.wdata[RATE1_LSB +: RATE_W]);
                    next_state.rate2 = rate_upd(state.rate2,
                        bus_req_i.wdata[RATE2_LSB +: RATE_W]);
                end
                // Status registers and unmapped addresses take no write
                default:
                    next_state = next_state;
            endcase
        end
        // Ratios track the codes one cycle later, so for one cycle after a write a downstream divider sees the new code with the old ratio
        next_state.ratio1 = ratio_of(state.div1);
        next_state.ratio2 = ratio_of(state.div2);
        next_state.act1   = first_input_selected_i & ~first_input_loss_live_i;
        next_state.act2   = second_input_selected_i & ~second_input_loss_live_i;
        next_state.loss[LOSS_SECOND_BIT] = second_input_loss_live_i;
        next_state.loss[LOSS_FIRST_BIT]  = first_input_loss_live_i;
        next_state.loss[LOSS_REF_BIT]    = reference_loss_live_i;
        if (bus_req_i.rd)
        begin
            next_state.rvalid = 1'b1;
            next_state.rdata  = READ_ZERO;
            unique case (bus_req_i.addr)
                ADDR_DIV1_HIGH:
                    next_state.rdata[DIV_HIGH_W-1:0] = state.div1[DIV_W-1:DIV_HIGH_LSB];
                ADDR_DIV1_MID:
                    next_state.rdata = state.div1[DIV_HIGH_LSB-1:DIV_MID_LSB];
                ADDR_DIV1_LOW:
                    next_state.rdata = state.div1[DIV_MID_LSB-1:0];
                ADDR_DIV2_HIGH:
                    next_state.rdata[DIV_HIGH_W-1:0] = state.div2[DIV_W-1:DIV_HIGH_LSB];
                ADDR_DIV2_MID:
                    next_state.rdata = state.div2[DIV_HIGH_LSB-1:DIV_MID_LSB];
                ADDR_DIV2_LOW:
                    next_state.rdata = state.div2[DIV_MID_LSB-1:0];
                ADDR_RATE_SELECT:
                begin
                    next_state.rdata[RATE1_LSB +: RATE_W] = state.rate1;
                    next_state.rdata[RATE2_LSB +: RATE_W] = state.rate2;
                end
                ADDR_ACTIVE:
                begin
                    // Reserved bit pattern is fixed at its reset reading
                    next_state.rdata           = ACTIVE_RSVD_VAL;
                    next_state.rdata[ACT1_BIT] = state.act1;
                    next_state.rdata[ACT2_BIT] = state.act2;
                end
                ADDR_LOSS_LIVE:
                    next_state.rdata[2:0] = state.loss;
                default:
                    next_state.rdata = READ_ZERO;
            endcase
        end
    end

    // State register with synchronous reset
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_b_i)
        begin
            state.div1   <= {DIV_HIGH_RST, DIV_MID_RST, DIV1_LOW_RST};
            state.div2   <= {DIV_HIGH_RST, DIV_MID_RST, DIV2_LOW_RST};
            state.ratio1 <= ratio_of({DIV_HIGH_RST, DIV_MID_RST, DIV1_LOW_RST});
            state.ratio2 <= ratio_of({DIV_HIGH_RST, DIV_MID_RST, DIV2_LOW_RST});
            state.rate1  <= RATE_RST;
            state.rate2  <= RATE_RST;
            state.act1   <= 1'b0;
            state.act2   <= 1'b0;
            state.loss   <= 3'h0;
            state.rdata  <= READ_ZERO;
            state.rvalid <= 1'b0;
        end
        else
        begin
            state <= next_state;
        end
    end

    // Outputs straight from the state flops
    assign rdata_o                   = state.rdata;
    assign rvalid_o                  = state.rvalid;
    assign first_input_divider_o     = state.div1;
    assign second_input_divider_o    = state.div2;
    assign first_input_ratio_o       = state.ratio1;
    assign second_input_ratio_o      = state.ratio2;
    assign first_input_range_code_o  = state.rate1;
    assign second_input_range_code_o = state.rate2;
    assign first_input_active_o      = state.act1;
    assign second_input_active_o     = state.act2;
    assign loss_live_o               = state.loss;

    // Ratio follows the code it was derived from one cycle earlier
    property p_ratio_tracks;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        $past(rst_b_i) |-> first_input_ratio_o == ratio_of($past(first_input_divider_o));
    endproperty
    a_ratio_tracks: assert property (p_ratio_tracks)
        else $error("first ratio is not code plus one");

    property p_div2_mid_write;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        (bus_req_i.wr && bus_req_i.addr == ADDR_DIV2_MID)
        |=> second_input_divider_o[15:8] == $past(bus_req_i.wdata);
    endproperty
    a_div2_mid_write: assert property (p_div2_mid_write)
        else $error("second divider middle byte not stored");

    property p_div2_high_rsvd;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        (bus_req_i.rd && bus_req_i.addr == ADDR_DIV2_HIGH)
        |=> rvalid_o && rdata_o[7:3] == 5'h00
            && rdata_o[2:0] == $past(second_input_divider_o[18:16]);
    endproperty
    a_div2_high_rsvd: assert property (p_div2_high_rsvd)
        else $error("second divider high read wrong");

    property p_div1_high_write;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        (bus_req_i.wr && bus_req_i.addr == ADDR_DIV1_HIGH)
        |=> first_input_divider_o[18:16] == $past(bus_req_i.wdata[2:0]);
    endproperty
    a_div1_high_write: assert property (p_div1_high_write)
        else $error("first divider high bits not stored");

    property p_rate_reserved;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        (bus_req_i.wr && bus_req_i.addr == ADDR_RATE_SELECT && bus_req_i.wdata[2:0] > 3'h5)
        |=> $stable(first_input_range_code_o);
    endproperty
    a_rate_reserved: assert property (p_rate_reserved)
        else $error("reserved range code accepted");

    property p_act1;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        $past(rst_b_i) |-> first_input_active_o ==
            ($past(first_input_selected_i) && !$past(first_input_loss_live_i));
    endproperty
    a_act1: assert property (p_act1)
        else $error("first active indicator wrong");

    property p_act2;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        second_input_loss_live_i |=> !second_input_active_o;
    endproperty
    a_act2: assert property (p_act2)
        else $error("second input active during loss");

    property p_loss_read;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        (bus_req_i.rd && bus_req_i.addr == ADDR_LOSS_LIVE)
        |=> rdata_o == {5'h00, $past(loss_live_o)};
    endproperty
    a_loss_read: assert property (p_loss_read)
        else $error("loss status read wrong");

    property p_loss_first;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        $rose(first_input_loss_live_i) |=> loss_live_o[1]
            ##1 (loss_live_o[1] == $past(first_input_loss_live_i));
    endproperty
    a_loss_first: assert property (p_loss_first)
        else $error("first loss bit not following alarm");

    property p_loss_ref;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        $past(rst_b_i) |-> loss_live_o[0] == $past(reference_loss_live_i);
    endproperty
    a_loss_ref: assert property (p_loss_ref)
        else $error("reference loss bit not following alarm");

    property p_status_write_ignored;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        (bus_req_i.wr && (bus_req_i.addr == ADDR_LOSS_LIVE || bus_req_i.addr == ADDR_ACTIVE))
        |=> $stable(first_input_divider_o) && $stable(second_input_divider_o)
            && $stable(first_input_range_code_o) && $stable(second_input_range_code_o);
    endproperty
    a_status_write_ignored: assert property (p_status_write_ignored)
        else $error("status write changed configuration");

    // Second ratio must track its own code, not just the first one's
    property p_ratio2_tracks;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        $past(rst_b_i) |-> second_input_ratio_o == ratio_of($past(second_input_divider_o));
    endproperty
    a_ratio2_tracks: assert property (p_ratio2_tracks)
        else $error("second ratio is not code plus one");

    // Low byte of the second divider lands alone, no shadowing
    property p_div2_low_write;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        (bus_req_i.wr && bus_req_i.addr == ADDR_DIV2_LOW)
        |=> second_input_divider_o[DIV_MID_LSB-1:0] == $past(bus_req_i.wdata);
    endproperty
    a_div2_low_write: assert property (p_div2_low_write)
        else $error("second divider low byte not stored");

    // Low byte of the first divider lands alone as well, no shadowing
    property p_div1_low_write;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        (bus_req_i.wr && bus_req_i.addr == ADDR_DIV1_LOW)
        |=> first_input_divider_o[DIV_MID_LSB-1:0] == $past(bus_req_i.wdata);
    endproperty
    a_div1_low_write: assert property (p_div1_low_write)
        else $error("first divider low byte not stored");

    // A reserved code in the upper field leaves the second range alone
    property p_rate2_reserved;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        (bus_req_i.wr && bus_req_i.addr == ADDR_RATE_SELECT
            && bus_req_i.wdata[RATE2_LSB +: RATE_W] > RATE_MAX_LEGAL)
        |=> $stable(second_input_range_code_o);
    endproperty
    a_rate2_reserved: assert property (p_rate2_reserved)
        else $error("reserved second range code accepted");

    // Indicator read shows the fixed pattern with both active bits
    property p_active_read;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        (bus_req_i.rd && bus_req_i.addr == ADDR_ACTIVE)
        |=> rdata_o == (ACTIVE_RSVD_VAL
            | {6'h00, $past(second_input_active_o), $past(first_input_active_o)});
    endproperty
    a_active_read: assert property (p_active_read)
        else $error("active indicator read wrong");

    // Both directions, so a stuck-low indicator is caught too
    property p_act2_full;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        $past(rst_b_i) |-> second_input_active_o ==
            ($past(second_input_selected_i) && !$past(second_input_loss_live_i));
    endproperty
    a_act2_full: assert property (p_act2_full)
        else $error("second active indicator wrong");

    // Second input loss bit follows its alarm with one cycle of lag
    property p_loss_second;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        $past(rst_b_i) |-> loss_live_o[LOSS_SECOND_BIT] == $past(second_input_loss_live_i);
    endproperty
    a_loss_second: assert property (p_loss_second)
        else $error("second loss bit not following alarm");

endmodule
`default_nettype wire

//--- idls_host_model.sv
`default_nettype none
module idls_host_model
    import idls_pkg::*;
(
    // Clock
    input  wire logic           ref_clk_i,
    // Register port towards the bank
    output var idls_bus_req_s   bus_req_o,
    input  wire logic [7:0]     rdata_i,
    input  wire logic           rvalid_i
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle port at time zero
    initial
    begin
        bus_req_o = '{wr: 1'b0, rd: 1'b0, addr: 8'h00, wdata: 8'h00};
    end

    // Released lines flip so a stale address or data never looks held
    task automatic release_bus();
        bus_req_o.wr    = 1'b0;
        bus_req_o.rd    = 1'b0;
        bus_req_o.addr  = ~bus_req_o.addr;
        bus_req_o.wdata = ~bus_req_o.wdata;
    endtask

    // One write strobe; reserved range codes only go out when the bench asks
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk_i);
        bus_req_o.wr    = 1'b1;
        bus_req_o.addr  = a;
        bus_req_o.wdata = d;
        @(negedge ref_clk_i);
        release_bus();
    endtask

    // One read strobe; the answer is registered, so it is there one edge later
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
        @(negedge ref_clk_i);
        bus_req_o.rd   = 1'b1;
        bus_req_o.addr = a;
        @(negedge ref_clk_i);
        release_bus();
        d  = rdata_i;
        ok = rvalid_i;
    endtask
endmodule
`default_nettype wire

//--- tb.sv
`default_nettype none
module tb
    import idls_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic               ref_clk_i = 1'b0;
    logic               rst_b_i = 1'b0;
    idls_bus_req_s      bus_req;
    logic [7:0]         rdata;
    logic               rvalid;
    logic [4:0]         live = 5'h00; // sel1, sel2, loss2, loss1, ref loss
    logic [DIV_W-1:0]   div1, div2, m_div1, m_div2;
    logic [DIV_W:0]     rat1, rat2;
    logic [RATE_W-1:0]  rc1, rc2, m_r1, m_r2;
    logic               act1, act2;
    logic [2:0]         loss;
    int                 failures = 0;
    int                 checks_done = 0;
    logic [7:0]         da[6] = '{8'h2b, 8'h2c, 8'h2d, 8'h2e, 8'h2f, 8'h30};

    // 200 MHz clock
    always #2.5 ref_clk_i = ~ref_clk_i;

    idls_regs idls_regs_i (
        .ref_clk_i                (ref_clk_i),
        .rst_b_i                  (rst_b_i),
        .bus_req_i                (bus_req),
        .rdata_o                  (rdata),
        .rvalid_o                 (rvalid),
        .first_input_selected_i   (live[4]),
        .second_input_selected_i  (live[3]),
        .first_input_loss_live_i  (live[1]),
        .second_input_loss_live_i (live[2]),
        .reference_loss_live_i    (live[0]),
        .first_input_divider_o    (div1),
        .second_input_divider_o   (div2),
        .first_input_ratio_o      (rat1),
        .second_input_ratio_o     (rat2),
        .first_input_range_code_o (rc1),
        .second_input_range_code_o(rc2),
        .first_input_active_o     (act1),
        .second_input_active_o    (act2),
        .loss_live_o              (loss)
    );

    idls_host_model idls_host_model_i (
        .ref_clk_i(ref_clk_i),
        .bus_req_o(bus_req),
        .rdata_i  (rdata),
        .rvalid_i (rvalid)
    );

    // Case equality so an unknown never passes
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Expected read data from the bench's own copy of the bank
    function automatic logic [7:0] exp_rd(input logic [7:0] a);
        case (a)
            8'h2b: return {5'h00, m_div1[18:16]};
            8'h2c: return m_div1[15:8];
            8'h2d: return m_div1[7:0];
            8'h2e: return {5'h00, m_div2[18:16]};
            8'h2f: return m_div2[15:8];
            8'h30: return m_div2[7:0];
            8'h37: return {2'b00, m_r2, m_r1};
            8'h80: return {6'h08, live[3] & ~live[2], live[4] & ~live[1]};
            8'h81: return {5'h00, live[2:0]};
            default: return 8'h00;
        endcase
    endfunction

    // Write, mirror into the copy, then check the configuration outputs
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        idls_host_model_i.write_reg(a, d);
        case (a)
            8'h2b: m_div1[18:16] = d[2:0];
            8'h2c: m_div1[15:8] = d;
            8'h2d: m_div1[7:0] = d;
            8'h2e: m_div2[18:16] = d[2:0];
            8'h2f: m_div2[15:8] = d;
            8'h30: m_div2[7:0] = d;
            8'h37:
            begin
                if (d[5:3] < 3'h6)
                    m_r2 = d[5:3];
                if (d[2:0] < 3'h6)
                    m_r1 = d[2:0];
            end
            default: ;
        endcase
        @(negedge ref_clk_i);
        check(div1, m_div1);
        check(div2, m_div2);
        check(rat1, {1'b0, m_div1} + 20'h1);
        check(rat2, {1'b0, m_div2} + 20'h1);
        check(rc1, m_r1);
        check(rc2, m_r2);
    endtask

    // Read one register; the valid pulse must last exactly one cycle
    task automatic rd(input logic [7:0] a);
        logic [7:0] d;
        logic       ok;
        idls_host_model_i.read_reg(a, d, ok);
        check(ok, 1'b1);
        check(d, exp_rd(a));
        @(negedge ref_clk_i);
        check(rvalid, 1'b0);
    endtask

    // New live conditions, given two edges to pass the status register
    task automatic set_live(input logic [4:0] v);
        live = v;
        repeat (2) @(negedge ref_clk_i);
        check(loss, live[2:0]);
        check({act2, act1}, {live[3] & ~live[2], live[4] & ~live[1]});
        rd(8'h80);
        rd(8'h81);
    endtask

    // Reset for four cycles, then compare every configuration register with its reset value and the status ones with the live inputs
    task automatic do_reset();
        rst_b_i = 1'b0;
        repeat (4) @(negedge ref_clk_i);
        rst_b_i = 1'b1;
        m_div1 = 19'h00009;
        m_div2 = 19'h00000;
        m_r1 = 3'h0;
        m_r2 = 3'h0;
        check(rat1, 20'h0000a);
        for (int i = 0; i < 6; i++)
            rd(da[i]);
        rd(8'h37);
        rd(8'h80);
        rd(8'h81);
    endtask

    task automatic wrap_up();
        $display("checks_done=%0d failures=%0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        void'($urandom(59));
        do_reset();
        for (int i = 0; i < 3; i++)
            wr(da[i], 8'h00);
        for (int i = 3; i < 6; i++)
            wr(da[i], 8'hff);
        for (int i = 0; i < 40; i++)
            wr(da[$urandom % 6], 8'($urandom));
        for (int i = 0; i < 6; i++)
            rd(da[i]);
        for (int c = 0; c < 8; c++)
        begin
            wr(8'h37, {2'b11, 3'(c), 3'(7 - c)});
            rd(8'h37);
        end
        for (int i = 0; i < 32; i++)
            set_live(5'(i));
        // Read-only and unmapped places must swallow writes
        wr(8'h80, 8'h00);
        wr(8'h81, 8'h00);
        wr(8'h5a, 8'hff);
        rd(8'h5a);
        set_live(5'($urandom));
        do_reset();
        wrap_up();
    end

    // Watchdog: the run needs a few hundred cycles at most
    initial
    begin
        #100000;
        failures++;
        wrap_up();
    end
endmodule
`default_nettype wire
